// ===== tb/column_line_model.sv
`timescale 1ns/10ps
module column_line_model (
  input wire logic [15:0] col_data_o,
  input wire logic col_oe,
  input wire logic [15:0] peer_data,
  input wire logic peer_oe,
  output logic [15:0] col_line,
  output logic clash,
  output logic floating
);
  logic [15:0] last_r = 16'h0000;
  // No keeper on the line: undriven shows the inverse, never a held copy
  always @* begin
    if (col_oe && !peer_oe) col_line = col_data_o;
    else if (peer_oe && !col_oe) col_line = peer_data;
    else col_line = ~last_r;
  end
  always @(col_line) if (col_oe ^ peer_oe) last_r = col_line;
  assign clash = col_oe & peer_oe;
  assign floating = !col_oe && !peer_oe;
endmodule

// ===== tb/embedded_memory_block_assertions.sv
`timescale 1ns/10ps
module embedded_memory_block_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire read_strobe,
  input wire [15:0] rd_data,
  input wire rd_valid,
  input wire [15:0] col_data_o,
  input wire col_oe,
  input wire fifo_full,
  input wire fifo_empty,
  input wire [31:0] pterm_i,
  input wire [15:0] mc_q,
  input wire [9:0] local_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_error_with_ready: assert property ($rose(pslverr) |-> pready)
    else $error("pslverr raised without pready");
  // ----------------------------------------
  // Fabric side
  // ----------------------------------------
  a_local_twin: assert property (local_out[9] == local_out[8] &&
    (local_out[8:0] == $past(rd_data[8:0]) || local_out[8:0] == $past(mc_q[8:0])))
    else $error("local_out is neither read data nor macrocell state");
  a_valid_cause: assert property (rd_valid |-> $past(read_strobe) || $past(read_strobe, 2))
    else $error("rd_valid without a read strobe");
  a_column_copy: assert property ($changed(col_data_o) |-> rd_valid)
    else $error("column data changed without a read result");
  a_flags_apart: assert property (!(fifo_full && fifo_empty))
    else $error("fifo full and empty together");
  a_term_gain: assert property ((mc_q & ~$past(mc_q)) != 16'h0 |-> $past(pterm_i) != 32'h0)
    else $error("macrocell set with no product term");
  cover property (rd_valid);
  cover property ($rose(pslverr));
  cover property ($fell(col_oe));
  cover property (fifo_full);
endmodule

bind embedded_memory_block embedded_memory_block_checker checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .read_strobe(read_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
  .col_data_o(col_data_o), .col_oe(col_oe), .fifo_full(fifo_full),
  .fifo_empty(fifo_empty), .pterm_i(pterm_i), .mc_q(mc_q), .local_out(local_out)
);

// ===== tb/testbench.sv
`timescale 1ns/10ps
`include "embedded_memory_block_regs.vh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat, prdata, pterm_i = 32'hFFFFFFFF;
  logic rerr, pready, pslverr, rd_valid, col_oe, fifo_full, fifo_empty, cam_hit;
  logic wr_en = 1'b0, read_strobe = 1'b0, clear_source_one = 1'b0, clear_source_two = 1'b0;
  logic [12:0] wr_addr = 13'h0000, rd_addr = 13'h0000;
  logic [15:0] wr_data = 16'h0000, rd_data, col_data_o, mc_q, col_line;
  logic [15:0] peer_data = 16'h7777;
  logic peer_oe = 1'b0, clash, floating;
  logic [9:0] local_out;
  int num_errors = 0;
  int tests_run = 0;
  always #5 pclk = ~pclk;
  embedded_memory_block embedded_memory_block_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .read_strobe(read_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .col_data_o(col_data_o),
    .col_oe(col_oe), .fifo_full(fifo_full), .fifo_empty(fifo_empty), .cam_hit(cam_hit),
    .clear_source_one(clear_source_one), .clear_source_two(clear_source_two),
    .pterm_i(pterm_i), .mc_q(mc_q), .local_out(local_out));
  column_line_model column_line_model_inst (.col_data_o(col_data_o), .col_oe(col_oe),
    .peer_data(peer_data), .peer_oe(peer_oe), .col_line(col_line), .clash(clash),
    .floating(floating));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      close_out;
    end
  endtask
  task fwrite(input logic [12:0] a, input logic [15:0] d);
    @(posedge pclk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge pclk);
    wr_en <= 1'b0;
  endtask
  task fread(input logic [12:0] a, input int lat, input logic [15:0] exp);
    @(posedge pclk);
    read_strobe <= 1'b1;
    rd_addr <= a;
    @(posedge pclk);
    read_strobe <= 1'b0;
    for (int i = 1; i < lat; i++) begin
      @(posedge pclk);
      chk(rd_valid, 0);
    end
    @(posedge pclk);
    chk(rd_valid, 1);
    chk(rd_data, exp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(0, `REG_CTRL, 0);
    chk(rdat, 0);
    apb(0, `REG_STATUS, 0);
    chk(rdat[`STATUS_EMPTY], 1);
    apb(0, 12'h01C, 0);
    chk(rerr, 1);
  endtask
  task t_shapes;
    logic [15:0] m;
    logic [12:0] top;
    for (int s = 0; s < 5; s++) begin
      apb(1, `REG_CTRL, s);
      m = 16'hFFFF >> (16 - (16 >> s));
      top = 13'((128 << s) - 1);
      fwrite(13'h0000, 16'hA5C3);
      fwrite(13'h0001, 16'h5A3C);
      fwrite(top, 16'h0F0F);
      fread(13'h0000, 1, 16'hA5C3 & m);
      fread(13'h0001, 1, 16'h5A3C & m);
      fread(top, 1, 16'h0F0F & m);
    end
  endtask
  task t_pages;
    apb(1, `REG_CTRL, 32'h82C);
    fwrite({2'h2, 11'h009}, 16'h0001);
    fwrite({2'h1, 11'h009}, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      peer_oe <= (p != 2);
      fread({2'(p), 11'h009}, 2, 16'h0001);
      @(posedge pclk);
      chk(col_oe, p == 2);
      chk({clash, floating}, 0);
      chk(col_line, (p == 2) ? 16'h0001 : 16'h7777);
    end
    peer_oe <= 1'b0;
  endtask
  task t_pterm;
    apb(1, `REG_CLRSEL, 32'h39);
    apb(1, `REG_CTRL, 32'h40);
    repeat (2) @(posedge pclk);
    chk(mc_q, 16'hFFFF);
    clear_source_one <= 1'b1;
    #2;
    chk(mc_q, 16'hFFFE);
    @(posedge pclk);
    clear_source_one <= 1'b0;
    clear_source_two <= 1'b1;
    #2;
    chk(mc_q, 16'hFFFC);
    @(posedge pclk);
    clear_source_two <= 1'b0;
    apb(1, `REG_CTRL, 32'hC0);
    #2;
    chk(mc_q, 16'hFFFE);
    chk(local_out, 10'h3FF);
    apb(1, `REG_CTRL, 32'h140);
    #2;
    chk(mc_q, 16'hFFFC);
  endtask
  task t_expand;
    apb(1, `REG_CLRSEL, 0);
    pterm_i <= 32'h80000000;
    apb(1, `REG_EXP_LO, 32'hF);
    repeat (2) @(posedge pclk);
    chk(mc_q, 16'h8001);
    apb(1, `REG_EXP_LO, 32'hE);
    repeat (2) @(posedge pclk);
    chk(mc_q, 16'h8000);
  endtask
  task t_modes;
    apb(1, `REG_CTRL, 32'h200);
    @(posedge pclk);
    chk(fifo_empty, 1);
    fwrite(13'h0000, 16'h1111);
    fwrite(13'h0000, 16'h2222);
    fread(13'h0000, 1, 16'h1111);
    fread(13'h0000, 1, 16'h2222);
    @(posedge pclk);
    chk(fifo_empty, 1);
    for (int i = 0; i < 128; i++) begin
      fwrite(13'(i), 16'(i));
    end
    @(posedge pclk);
    chk(fifo_full, 1);
    fread(13'h0000, 1, 16'h0000);
    chk(fifo_full, 0);
    apb(1, `REG_CTRL, 32'h400);
    apb(1, `REG_LOAD_ADDR, 32'h3);
    apb(1, `REG_LOAD_DATA, 32'hBEEF);
    fwrite(13'h0003, 16'h0000);
    fread(13'h0003, 1, 16'hBEEF);
    apb(1, `REG_CTRL, 32'h600);
    apb(1, `REG_LOAD_ADDR, 32'h1);
    apb(1, `REG_LOAD_DATA, 32'h5AA5);
    wr_data <= 16'h5AA5;
    fread(13'h0000, 1, 16'h0001);
    chk(cam_hit, 1);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    chk(fifo_empty, 1);
    chk({local_out, mc_q}, 0);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_shapes;
    t_pages;
    t_pterm;
    t_expand;
    t_modes;
    close_out;
  end
  initial begin
    #500000;
    num_errors++;
    close_out;
  end
endmodule

// ===== verilog/embedded_memory_block.v
`timescale 1ns/10ps
`include "embedded_memory_block_regs.vh"
module embedded_memory_block (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire wr_en,
  input wire [12:0] wr_addr,
  input wire [15:0] wr_data,
  input wire read_strobe,
  input wire [12:0] rd_addr,
  output wire [15:0] rd_data,
  output wire rd_valid,
  output wire [15:0] col_data_o,
  output wire col_oe,
  output wire fifo_full,
  output wire fifo_empty,
  output wire cam_hit,
  input wire clear_source_one,
  input wire clear_source_two,
  input wire [31:0] pterm_i,
  output wire [15:0] mc_q,
  output wire [9:0] local_out
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function [2:0] fn_shape;
    input [2:0] s;
    begin
      fn_shape = (s > `SHAPE_MAX) ? `SHAPE_MAX : s;
    end
  endfunction

  function [15:0] fn_mask;
    input [2:0] s;
    begin
      case (s)
        3'h0: fn_mask = 16'hFFFF;
        3'h1: fn_mask = 16'h00FF;
        3'h2: fn_mask = 16'h000F;
        3'h3: fn_mask = 16'h0003;
        default: fn_mask = 16'h0001;
      endcase
    end
  endfunction

  function [6:0] fn_row;
    input [10:0] a;
    input [2:0] s;
    reg [10:0] sh;
    begin
      sh = a >> s;
      fn_row = sh[6:0];
    end
  endfunction

  function [3:0] fn_shift;
    input [10:0] a;
    input [2:0] s;
    reg [3:0] lane;
    begin
      lane = a[3:0] & ~(4'hF << s);
      fn_shift = lane << (3'h4 - s);
    end
  endfunction

  function [10:0] fn_inc;
    input [10:0] p;
    input [10:0] last;
    begin
      fn_inc = (p == last) ? 11'h000 : p + 11'h001;
    end
  endfunction

  function fn_page_hit;
    input en;
    input [1:0] sel;
    input [1:0] pg;
    begin
      fn_page_hit = ~en | (pg == sel);
    end
  endfunction

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  reg [11:0] ctrl_r;
  reg [31:0] clrsel_r;
  reg [63:0] exp_r;
  reg [10:0] load_addr_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] rd_mux;
  reg rd_bad;

  wire [2:0] shape = fn_shape(ctrl_r[`CTRL_SHAPE_HI:`CTRL_SHAPE_LO]);
  wire [1:0] mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire page_en = ctrl_r[`CTRL_PAGE_EN];
  wire [1:0] page_sel = ctrl_r[`CTRL_PAGE_HI:`CTRL_PAGE_LO];
  wire pterm_mode = ctrl_r[`CTRL_PTERM];
  wire out_reg = ctrl_r[`CTRL_OUT_REG];
  wire is_fifo = (mode == `MODE_FIFO);
  wire is_cam = (mode == `MODE_CAM);
  wire [15:0] wmask = fn_mask(shape);
  wire [10:0] last = 11'h7FF >> (3'h4 - shape);

  // ----------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------
  wire setup = psel & ~penable & ~pready_r;
  wire wr_take = psel & penable & pready_r & pwrite;
  wire ctrl_we = wr_take & (paddr == `REG_CTRL);
  wire load_we = wr_take & (paddr == `REG_LOAD_DATA);

  reg [10:0] wptr_r;
  reg [10:0] rptr_r;
  reg [11:0] count_r;
  reg [11:0] count_nxt;
  reg full_r;
  reg empty_r;
  reg cam_hit_r;
  wire [15:0] rb_data;
  wire [15:0] ra_data;
  wire core_cam_hit;
  wire [6:0] core_cam_row;

  always @* begin
    rd_mux = 32'h00000000;
    rd_bad = 1'b0;
    case (paddr)
      `REG_CTRL: rd_mux = {20'h00000, ctrl_r};
      `REG_CLRSEL: rd_mux = clrsel_r;
      `REG_EXP_LO: rd_mux = exp_r[31:0];
      `REG_EXP_HI: rd_mux = exp_r[63:32];
      `REG_LOAD_ADDR: rd_mux = {21'h000000, load_addr_r};
      `REG_LOAD_DATA: rd_mux = {16'h0000,
        (rb_data >> fn_shift(load_addr_r, shape)) & wmask};
      `REG_STATUS: rd_mux = {mc_q, 1'b0, cam_hit_r, full_r, empty_r, count_r};
      default: rd_bad = 1'b1;
    endcase
  end

  // Read data is a snapshot taken in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        prdata_r <= rd_mux;
        pslverr_r <= rd_bad;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
      clrsel_r <= `CLRSEL_RESET;
      exp_r <= `EXP_RESET;
      load_addr_r <= 11'h000;
    end else if (wr_take) begin
      case (paddr)
        `REG_CTRL: ctrl_r <= pwdata[11:0];
        `REG_CLRSEL: clrsel_r <= pwdata;
        `REG_EXP_LO: exp_r[31:0] <= pwdata;
        `REG_EXP_HI: exp_r[63:32] <= pwdata;
        `REG_LOAD_ADDR: load_addr_r <= pwdata[10:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  // Software load wins a same-cycle collision; the fabric write is dropped
  wire fab_we = wr_en & ~load_we & (is_fifo ? ~full_r :
    ((mode != `MODE_ROM) & fn_page_hit(page_en, page_sel, wr_addr[12:11])));
  wire [10:0] fab_wa = is_fifo ? wptr_r : wr_addr[10:0];
  wire [10:0] core_wa = load_we ? load_addr_r : fab_wa;
  wire [15:0] core_wd = load_we ? pwdata[15:0] : wr_data;
  wire [3:0] wshift = fn_shift(core_wa, shape);
  wire [15:0] core_mask = wmask << wshift;
  wire [15:0] core_bits = (core_wd & wmask) << wshift;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire push = fab_we & is_fifo;
  wire pop = read_strobe & is_fifo & ~empty_r;
  wire rd_go = read_strobe & (~is_fifo | ~empty_r);
  wire [10:0] fab_ra = is_fifo ? rptr_r : rd_addr[10:0];
  wire [15:0] fresh = is_cam ? {9'h000, core_cam_row} :
    ((ra_data >> fn_shift(fab_ra, shape)) & wmask);

  memory_array u_array (
    .pclk(pclk),
    .wr_en(fab_we | load_we),
    .wr_row(fn_row(core_wa, shape)),
    .wr_mask(core_mask),
    .wr_bits(core_bits),
    .ra_row(fn_row(fab_ra, shape)),
    .ra_data(ra_data),
    .rb_row(fn_row(load_addr_r, shape)),
    .rb_data(rb_data),
    .cam_key(wr_data),
    .cam_hit(core_cam_hit),
    .cam_row(core_cam_row)
  );

  // ----------------------------------------
  // FIFO pointers, restarted by any control write
  // ----------------------------------------
  always @* begin
    case ({push, pop})
      2'b10: count_nxt = count_r + 12'h001;
      2'b01: count_nxt = count_r - 12'h001;
      default: count_nxt = count_r;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= 11'h000;
      rptr_r <= 11'h000;
      count_r <= 12'h000;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else if (ctrl_we) begin
      wptr_r <= 11'h000;
      rptr_r <= 11'h000;
      count_r <= 12'h000;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      if (push) begin
        wptr_r <= fn_inc(wptr_r, last);
      end
      if (pop) begin
        rptr_r <= fn_inc(rptr_r, last);
      end
      count_r <= count_nxt;
      full_r <= (count_nxt == ({1'b0, last} + 12'h001));
      empty_r <= (count_nxt == 12'h000);
    end
  end

  // ----------------------------------------
  // Output stages and column drive
  // ----------------------------------------
  reg [15:0] w1_r;
  reg v1_r;
  reg [15:0] dout_r;
  reg valid_r;
  reg [1:0] rd_page_r;
  reg col_oe_r;
  reg [8:0] local_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1_r <= 16'h0000;
      v1_r <= 1'b0;
      dout_r <= 16'h0000;
      valid_r <= 1'b0;
      cam_hit_r <= 1'b0;
      rd_page_r <= 2'h0;
      col_oe_r <= 1'b0;
      local_r <= 9'h000;
    end else begin
      v1_r <= rd_go;
      if (rd_go) begin
        w1_r <= fresh;
        rd_page_r <= rd_addr[12:11];
      end
      if (rd_go & is_cam) begin
        cam_hit_r <= core_cam_hit;
      end
      if (out_reg) begin
        valid_r <= v1_r;
        if (v1_r) begin
          dout_r <= w1_r;
        end
      end else begin
        valid_r <= rd_go;
        if (rd_go) begin
          dout_r <= fresh;
        end
      end
      // With page_en set, the held page keeps exactly one block on the column between reads; with it clear this block always drives
      col_oe_r <= fn_page_hit(page_en, page_sel, rd_page_r);
      local_r <= pterm_mode ? mc_q[8:0] : dout_r[8:0];
    end
  end

  // ----------------------------------------
  // Product-term macrocells
  // ----------------------------------------
  macrocell_array u_mc (
    .pclk(pclk),
    .presetn(presetn),
    .pterm_i(pterm_i),
    .exp_cnt(exp_r),
    .clr_sel(clrsel_r),
    .clr_one(clear_source_one ^ ctrl_r[`CTRL_INV_ONE]),
    .clr_two(clear_source_two ^ ctrl_r[`CTRL_INV_TWO]),
    .hold(~pterm_mode),
    .mc_q(mc_q)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rd_data = dout_r;
  assign rd_valid = valid_r;
  assign col_data_o = dout_r;
  assign col_oe = col_oe_r;
  assign fifo_full = full_r;
  assign fifo_empty = empty_r;
  assign cam_hit = cam_hit_r;
  assign local_out = {local_r[8], local_r};

endmodule

// ===== verilog/embedded_memory_block_regs.vh
`ifndef EMBEDDED_MEMORY_BLOCK_REGS_VH
`define EMBEDDED_MEMORY_BLOCK_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_CLRSEL 12'h004
`define REG_EXP_LO 12'h008
`define REG_EXP_HI 12'h00C
`define REG_LOAD_ADDR 12'h010
`define REG_LOAD_DATA 12'h014
`define REG_STATUS 12'h018

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CTRL_SHAPE_LO 0
`define CTRL_SHAPE_HI 2
`define CTRL_PAGE_EN 3
`define CTRL_PAGE_LO 4
`define CTRL_PAGE_HI 5
`define CTRL_PTERM 6
`define CTRL_INV_ONE 7
`define CTRL_INV_TWO 8
`define CTRL_MODE_LO 9
`define CTRL_MODE_HI 10
`define CTRL_OUT_REG 11
`define CTRL_RESET 12'h000
`define CLRSEL_RESET 32'h00000000
`define EXP_RESET 64'h0000000000000000

`define MODE_RAM 2'h0
`define MODE_FIFO 2'h1
`define MODE_ROM 2'h2
`define MODE_CAM 2'h3

`define CLR_NONE 2'h0
`define CLR_ONE 2'h1
`define CLR_TWO 2'h2

`define SHAPE_MAX 3'h4
`define STATUS_EMPTY 12
`define STATUS_FULL 13
`define STATUS_CAM_HIT 14

`endif

// ===== verilog/macrocell_array.v
`timescale 1ns/10ps
`include "embedded_memory_block_regs.vh"
module macrocell_array (
  input wire pclk,
  input wire presetn,
  input wire [31:0] pterm_i,
  input wire [63:0] exp_cnt,
  input wire [31:0] clr_sel,
  input wire clr_one,
  input wire clr_two,
  input wire hold,
  output wire [15:0] mc_q
);

  genvar g;

  generate
    for (g = 0; g < 16; g = g + 1) begin : mc
      reg q_r;
      reg sum;
      wire clr_n;
      integer k;

      // Combinational clear into an async pin: glitches on the sources clear too
      assign clr_n = presetn
        & ~((clr_sel[2*g+1:2*g] == `CLR_ONE) & clr_one)
        & ~((clr_sel[2*g+1:2*g] == `CLR_TWO) & clr_two);

      // Each extra set costs one more OR level in silicon
      always @* begin
        sum = pterm_i[2*g] | pterm_i[2*g+1];
        for (k = 1; k < 16; k = k + 1) begin
          if (exp_cnt[4*g+3:4*g] >= k[3:0]) begin
            sum = sum | pterm_i[2*((g+k)%16)] | pterm_i[2*((g+k)%16)+1];
          end
        end
      end

      always @(posedge pclk or negedge clr_n) begin
        if (!clr_n) begin
          q_r <= 1'b0;
        end else if (!hold) begin
          q_r <= sum;
        end
      end

      assign mc_q[g] = q_r;
    end
  endgenerate

endmodule

// ===== verilog/memory_array.v
`timescale 1ns/10ps
module memory_array (
  input wire pclk,
  input wire wr_en,
  input wire [6:0] wr_row,
  input wire [15:0] wr_mask,
  input wire [15:0] wr_bits,
  input wire [6:0] ra_row,
  output wire [15:0] ra_data,
  input wire [6:0] rb_row,
  output wire [15:0] rb_data,
  input wire [15:0] cam_key,
  output reg cam_hit,
  output reg [6:0] cam_row
);

  // ----------------------------------------
  // Storage, 128 rows of 16 bits
  // ----------------------------------------
  reg [15:0] mem_r [0:127];
  integer i;

  assign ra_data = mem_r[ra_row];
  assign rb_data = mem_r[rb_row];

  // Write strobe is the clock edge itself, so no pulse timing reaches the fabric
  always @(posedge pclk) begin
    if (wr_en) begin
      mem_r[wr_row] <= (mem_r[wr_row] & ~wr_mask) | (wr_bits & wr_mask);
    end
  end

  // ----------------------------------------
  // Search, lowest matching row wins
  // ----------------------------------------
  always @* begin
    cam_hit = 1'b0;
    cam_row = 7'h00;
    for (i = 0; i < 128; i = i + 1) begin
      if (!cam_hit && mem_r[i] == cam_key) begin
        cam_hit = 1'b1;
        cam_row = i[6:0];
      end
    end
  end

endmodule
